/* include/tlic_pkg.sv */
// Shared constants and types for the two-level interrupt controller.
package tlic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle timing
  localparam int OSC_PER_STATE = 2;
  localparam int STATES_PER_CYCLE = 6;
  localparam int OSC_PER_CYCLE = OSC_PER_STATE * STATES_PER_CYCLE;
  localparam int SAMPLE_STATE_NUM = 5;

  typedef enum logic [5:0] {
    TLIC_S1 = 6'h01,
    TLIC_S2 = 6'h02,
    TLIC_S3 = 6'h04,
    TLIC_S4 = 6'h08,
    TLIC_S5 = 6'h10,
    TLIC_S6 = 6'h20
  } tlic_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Sources, in polling order (index 0 polled first)
  localparam int NUM_SRC_MAX = 6;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TIMER0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TIMER1 = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_TIMER2 = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the enable and priority registers
  localparam int GLOBAL_ENABLE_BIT = 7;
  localparam int PRIO_DISABLE_BIT = 7;
  localparam int RESERVED_BIT = 6;
  // Enable/priority bit of each source, indexed by polling position
  localparam logic [2:0] SRC_BIT_POS [NUM_SRC_MAX] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses on the bus)
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_PRIORITY = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_CORE = 8'h10;
  localparam logic [7:0] ADDR_VECTOR = 8'h14;

  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] PRIORITY_RESET = 8'h00;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // Status / mask bits
  localparam int EV_CALL = 0;
  localparam int EV_RETURN = 1;
  localparam int EV_PLAIN_RETURN = 2;
  localparam int EV_WIDTH = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Service start addresses: base plus stride times polling position
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam logic [15:0] VECTOR_STRIDE = 16'h0008;

endpackage : tlic_pkg

/* hw/tlic_cycle_gen.sv */
// Machine cycle sequencer: six states of two oscillator periods each.
module tlic_cycle_gen (
  input wire logic clk_sys,
  input wire logic rst_n,
  output tlic_pkg::tlic_state_type state_o,
  output logic phase2_o,
  output logic sample_en_o,
  output logic poll_en_o
);

  tlic_pkg::tlic_state_type state_q;
  logic phase2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Phase toggles every oscillator period; state steps after phase 2
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase2_q <= 1'b0;
    end else begin
      phase2_q <= ~phase2_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= tlic_pkg::TLIC_S1;
    end else if (phase2_q) begin
      unique case (state_q)
        tlic_pkg::TLIC_S1: state_q <= tlic_pkg::TLIC_S2;
        tlic_pkg::TLIC_S2: state_q <= tlic_pkg::TLIC_S3;
        tlic_pkg::TLIC_S3: state_q <= tlic_pkg::TLIC_S4;
        tlic_pkg::TLIC_S4: state_q <= tlic_pkg::TLIC_S5;
        tlic_pkg::TLIC_S5: state_q <= tlic_pkg::TLIC_S6;
        tlic_pkg::TLIC_S6: state_q <= tlic_pkg::TLIC_S1;
        default: state_q <= tlic_pkg::TLIC_S1;
      endcase
    end
  end

  assign state_o = state_q;
  assign phase2_o = phase2_q;
  // Last period of S5: flags are latched here
  assign sample_en_o = (state_q == tlic_pkg::TLIC_S5) && phase2_q;
  // First period of the next cycle: latched samples are polled
  assign poll_en_o = (state_q == tlic_pkg::TLIC_S1) && !phase2_q;

endmodule : tlic_cycle_gen

/* hw/tlic_poll_pick.sv */
// Two-level priority resolver with fixed polling order inside a level.
module tlic_poll_pick #(
  parameter int NUM_SRC = 6
) (
  input wire logic [NUM_SRC-1:0] sample_i,
  input wire logic [7:0] enable_i,
  input wire logic [7:0] priority_i,
  input wire logic prio_off_i,
  input wire logic high_busy_i,
  input wire logic low_busy_i,
  output logic valid_o,
  output logic [2:0] index_o,
  output logic high_o
);

  // Lowest set bit wins: index 0 is polled first
  function automatic logic [2:0] first_set(input logic [NUM_SRC-1:0] vec);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : first_set

  logic [NUM_SRC-1:0] armed;
  logic [NUM_SRC-1:0] high_req;
  logic [NUM_SRC-1:0] low_req;

  always_comb begin
    armed = '0;
    high_req = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      armed[i] = sample_i[i] && enable_i[tlic_pkg::SRC_BIT_POS[i]]
        && enable_i[tlic_pkg::GLOBAL_ENABLE_BIT];
      // With priority logic stopped every source counts as low level
      high_req[i] = armed[i] && priority_i[tlic_pkg::SRC_BIT_POS[i]]
        && !prio_off_i;
    end
    low_req = armed & ~high_req;
  end

  always_comb begin
    valid_o = 1'b0;
    index_o = 3'h0;
    high_o = 1'b0;
    if (high_busy_i) begin
      valid_o = 1'b0;
    end else if (|high_req) begin
      valid_o = 1'b1;
      index_o = first_set(high_req);
      high_o = 1'b1;
    end else if (|low_req && !low_busy_i) begin
      valid_o = 1'b1;
      index_o = first_set(low_req);
    end
  end

endmodule : tlic_poll_pick

/* hw/tlic_top.sv */
// Two-level vectored interrupt controller with a classic Wishbone register slave.
//
// Function
// - Machine cycle is six states S1..S6, two oscillator periods each.
// - Five sources, plus a sixth for the third timer on larger variants.
// - Enable register bit 7 gates every request globally.
// - Enable bits 5..0 enable timer2, serial, timer1, ext1, timer0, ext0.
// - Priority bits at the same positions; one selects the high level.
// - Low-level routine is preempted only by a high-level request.
// - Nothing vectors while a high-level routine is in progress.
// - Among pending levels the higher level is serviced first.
// - Within a level a fixed polling order picks the winner.
// - Flags latched in state 5, evaluated in the next machine cycle.
// - Enabled unblocked sample makes the core long-call the source's fixed vector.
// - Requests blocked while equal or higher level routine runs.
// - The call pushes only the program counter and loads the vector.
// - Return from interrupt clears the in-progress flag of the served level.
// - Priority register bit 7 set stops priority; only enables then matter.
// - Return with nothing in progress acts as an ordinary return.
module tlic_top #(
  parameter int NUM_SRC = 6,
  parameter bit HAS_PRIO_DISABLE = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Request flags from timers, serial port and external input logic
  input wire logic [NUM_SRC-1:0] src_flag_i,
  // Hardware call towards the core
  output logic call_req_o,
  output logic [15:0] call_vector_o,
  output logic [2:0] call_source_o,
  output logic call_high_o,
  input wire logic call_ack_i,
  // Return-from-interrupt executed by the core
  input wire logic return_from_interrupt_i,
  output logic plain_return_o,
  // Status towards the core and the system
  output logic high_in_progress_o,
  output logic low_in_progress_o,
  output logic [5:0] machine_state_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Writable bits: reserved bit 6 never stored, absent sources dropped
  localparam logic [7:0] SRC_MASK = 8'((1 << NUM_SRC) - 1);
  localparam logic [7:0] ENABLE_WMASK = SRC_MASK
    | (8'h01 << tlic_pkg::GLOBAL_ENABLE_BIT);
  localparam logic [7:0] PRIORITY_WMASK = SRC_MASK
    | (HAS_PRIO_DISABLE ? (8'h01 << tlic_pkg::PRIO_DISABLE_BIT) : 8'h00);

  function automatic logic [15:0] vector_of(input logic [2:0] idx);
    return 16'(tlic_pkg::VECTOR_BASE + 16'(idx) * tlic_pkg::VECTOR_STRIDE);
  endfunction : vector_of

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle sequencer
  tlic_pkg::tlic_state_type state;
  logic phase2;
  logic sample_en;
  logic poll_en;

  tlic_cycle_gen u_cycle (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .state_o(state),
    .phase2_o(phase2),
    .sample_en_o(sample_en),
    .poll_en_o(poll_en)
  );

  assign machine_state_o = state;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] enable_q;
  logic [7:0] priority_q;
  logic [tlic_pkg::EV_WIDTH-1:0] status_q;
  logic [tlic_pkg::EV_WIDTH-1:0] mask_q;
  logic [NUM_SRC-1:0] sample_q;
  logic high_busy_q;
  logic low_busy_q;
  logic call_req_q;
  logic [15:0] call_vector_q;
  logic [2:0] call_source_q;
  logic call_high_q;
  logic plain_return_q;
  logic wb_ack_q;
  logic [31:0] wb_dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic bus_req;
  logic bus_write;
  logic bus_read;
  logic lane0;

  assign bus_req = wb_cyc_i && wb_stb_i;
  // Write lands on the edge the master sees ack
  assign bus_write = bus_req && wb_we_i && wb_ack_q;
  assign bus_read = bus_req && !wb_we_i && !wb_ack_q;
  assign lane0 = wb_sel_i[0];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_q <= 1'b0;
    end else begin
      wb_ack_q <= bus_req && !wb_ack_q;
    end
  end

  assign wb_ack_o = wb_ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Enable and priority registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= tlic_pkg::ENABLE_RESET;
    end else if (bus_write && lane0 && wb_adr_i == tlic_pkg::ADDR_ENABLE) begin
      enable_q <= wb_dat_i[7:0] & ENABLE_WMASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      priority_q <= tlic_pkg::PRIORITY_RESET;
    end else if (bus_write && lane0 && wb_adr_i == tlic_pkg::ADDR_PRIORITY) begin
      priority_q <= wb_dat_i[7:0] & PRIORITY_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag sampling: flags are same-clock logic, no synchroniser needed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sample_q <= '0;
    end else if (sample_en) begin
      sample_q <= src_flag_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Poll and pick
  logic pick_valid;
  logic [2:0] pick_index;
  logic pick_high;
  logic issue;

  tlic_poll_pick #(
    .NUM_SRC(NUM_SRC)
  ) u_pick (
    .sample_i(sample_q),
    .enable_i(enable_q),
    .priority_i(priority_q),
    .prio_off_i(priority_q[tlic_pkg::PRIO_DISABLE_BIT]),
    .high_busy_i(high_busy_q),
    .low_busy_i(low_busy_q),
    .valid_o(pick_valid),
    .index_o(pick_index),
    .high_o(pick_high)
  );

  // One call at a time; a poll while the core still owes an ack is skipped
  assign issue = poll_en && pick_valid && !call_req_q;

  ////////////////////////////////////////////////////////////////////////////
  // Hardware call towards the core
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      call_req_q <= 1'b0;
    end else if (issue) begin
      call_req_q <= 1'b1;
    end else if (call_ack_i) begin
      call_req_q <= 1'b0;
    end
  end

  // Core pushes the program counter only, then jumps to the vector
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      call_vector_q <= 16'h0000;
      call_source_q <= 3'h0;
      call_high_q <= 1'b0;
    end else if (issue) begin
      call_vector_q <= vector_of(pick_index);
      call_source_q <= pick_index;
      call_high_q <= pick_high;
    end
  end

  assign call_req_o = call_req_q;
  assign call_vector_o = call_vector_q;
  assign call_source_o = call_source_q;
  assign call_high_o = call_high_q;

  ////////////////////////////////////////////////////////////////////////////
  // In-progress flags; a new call sets before a same-cycle return clears
  logic ret_high;
  logic ret_low;
  logic ret_plain;

  // The high level finishes first: it is always the innermost routine
  assign ret_high = return_from_interrupt_i && high_busy_q;
  assign ret_low = return_from_interrupt_i && !high_busy_q && low_busy_q;
  assign ret_plain = return_from_interrupt_i && !high_busy_q && !low_busy_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      high_busy_q <= 1'b0;
    end else if (issue && pick_high) begin
      high_busy_q <= 1'b1;
    end else if (ret_high) begin
      high_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_busy_q <= 1'b0;
    end else if (issue && !pick_high) begin
      low_busy_q <= 1'b1;
    end else if (ret_low) begin
      low_busy_q <= 1'b0;
    end
  end

  // Nothing to clear: the core treats it as an ordinary return
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      plain_return_q <= 1'b0;
    end else begin
      plain_return_q <= ret_plain;
    end
  end

  assign plain_return_o = plain_return_q;
  assign high_in_progress_o = high_busy_q;
  assign low_in_progress_o = low_busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt line
  logic [tlic_pkg::EV_WIDTH-1:0] events;
  logic [tlic_pkg::EV_WIDTH-1:0] status_clr;

  always_comb begin
    events = '0;
    events[tlic_pkg::EV_CALL] = issue;
    events[tlic_pkg::EV_RETURN] = ret_high || ret_low;
    events[tlic_pkg::EV_PLAIN_RETURN] = ret_plain;
  end

  assign status_clr = (bus_write && lane0 && wb_adr_i == tlic_pkg::ADDR_STATUS)
    ? wb_dat_i[tlic_pkg::EV_WIDTH-1:0] : '0;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= tlic_pkg::STATUS_RESET;
    end else begin
      status_q <= (status_q & ~status_clr) | events;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= tlic_pkg::MASK_RESET;
    end else if (bus_write && lane0 && wb_adr_i == tlic_pkg::ADDR_MASK) begin
      mask_q <= wb_dat_i[tlic_pkg::EV_WIDTH-1:0];
    end
  end

  assign irq_o = |(status_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured when ack is raised; unmapped reads return zero
  logic [31:0] rd_data;

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      tlic_pkg::ADDR_ENABLE: rd_data[7:0] = enable_q;
      tlic_pkg::ADDR_PRIORITY: rd_data[7:0] = priority_q;
      tlic_pkg::ADDR_STATUS: rd_data[tlic_pkg::EV_WIDTH-1:0] = status_q;
      tlic_pkg::ADDR_MASK: rd_data[tlic_pkg::EV_WIDTH-1:0] = mask_q;
      tlic_pkg::ADDR_CORE: begin
        rd_data[0] = high_busy_q;
        rd_data[1] = low_busy_q;
        rd_data[2] = call_req_q;
        rd_data[3] = phase2;
        rd_data[13:8] = state;
        rd_data[16 +: NUM_SRC] = sample_q;
      end
      tlic_pkg::ADDR_VECTOR: begin
        rd_data[15:0] = call_vector_q;
        rd_data[18:16] = call_source_q;
        rd_data[20] = call_high_q;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_q <= 32'h0000_0000;
    end else if (bus_read) begin
      wb_dat_q <= rd_data;
    end
  end

  assign wb_dat_o = wb_dat_q;

endmodule : tlic_top

/* sim/tlic_core_model.sv */
// Behavioural core model: answers each hardware call after a set delay.
module tlic_core_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic call_req,
  input wire logic [3:0] ack_delay,
  output logic call_ack
);
  logic [3:0] wait_q;
  logic live;

  // The call counts as done once the return address is pushed
  assign live = call_req && !call_ack;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      call_ack <= 1'b0;
    end else begin
      call_ack <= live && wait_q == ack_delay;
      wait_q <= (live && wait_q != ack_delay) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : tlic_core_model

/* sim/tlic_top_properties.sv */
// Port-level checks for the two-level interrupt controller.
module tlic_top_properties #(
  parameter int NUM_SRC = 6,
  parameter bit HAS_PRIO_DISABLE = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [NUM_SRC-1:0] src_flag_i,
  input wire logic call_req_o,
  input wire logic [15:0] call_vector_o,
  input wire logic [2:0] call_source_o,
  input wire logic call_high_o,
  input wire logic call_ack_i,
  input wire logic return_from_interrupt_i,
  input wire logic plain_return_o,
  input wire logic high_in_progress_o,
  input wire logic low_in_progress_o,
  input wire logic [5:0] machine_state_o
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic [5:0] state_prev_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_prev_q <= 6'h01;
    end else begin
      state_prev_q <= machine_state_o;
    end
  end

  //////////////////////////////////////////////////////////////
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_state_step;
    $stable(machine_state_o) ##1 $changed(machine_state_o);
  endsequence
  sequence s_issue;
    $rose(call_req_o);
  endsequence

  a_ack_pulse: assert property (s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");
  a_state_rotate: assert property ($changed(machine_state_o) |->
    machine_state_o == {state_prev_q[4:0], state_prev_q[5]}) else $error("state order");
  a_state_pace: assert property ($changed(machine_state_o) |=> s_state_step)
    else $error("state length not two clocks");
  a_issue_in_s1: assert property (s_issue |-> machine_state_o == 6'h01)
    else $error("call outside first state");
  a_vector_fixed: assert property (call_req_o |->
    call_vector_o == 16'h0003 + 16'h0008 * {13'h0, call_source_o}) else $error("vector");
  a_req_hold: assert property (call_req_o && !call_ack_i |=>
    call_req_o && $stable(call_vector_o) && $stable(call_high_o)) else $error("call dropped");
  a_req_release: assert property (call_req_o && call_ack_i |=> !call_req_o)
    else $error("call held after push");
  a_high_blocks: assert property (s_issue |-> !$past(high_in_progress_o))
    else $error("call during high routine");
  a_low_preempt: assert property (s_issue and $past(low_in_progress_o) |->
    call_high_o) else $error("low call during low routine");
  a_level_flag: assert property (s_issue |->
    (call_high_o ? high_in_progress_o : low_in_progress_o)) else $error("level flag not set");
  a_return_high: assert property (return_from_interrupt_i && high_in_progress_o |=>
    !high_in_progress_o && low_in_progress_o == $past(low_in_progress_o))
    else $error("return did not clear high level");
  a_plain_return: assert property (return_from_interrupt_i && !high_in_progress_o &&
    !low_in_progress_o |=> plain_return_o ##1 !plain_return_o) else $error("plain return");
endmodule : tlic_top_properties

bind tlic_top tlic_top_properties #(.NUM_SRC(NUM_SRC), .HAS_PRIO_DISABLE(HAS_PRIO_DISABLE))
  u_props (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .src_flag_i(src_flag_i), .call_req_o(call_req_o),
  .call_vector_o(call_vector_o), .call_source_o(call_source_o), .call_high_o(call_high_o),
  .call_ack_i(call_ack_i), .return_from_interrupt_i(return_from_interrupt_i),
  .plain_return_o(plain_return_o), .high_in_progress_o(high_in_progress_o),
  .low_in_progress_o(low_in_progress_o), .machine_state_o(machine_state_o));

/* sim/tb_top.sv */
// Self-checking bench for the two-level interrupt controller.
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t %s", $time, m); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, return_from_interrupt = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [5:0] flags = 6'h00;
  logic [3:0] dly = 4'h0;
  logic ack, creq, chigh, cack, plain, hbusy, lbusy, irq;
  logic [15:0] cvec;
  logic [2:0] csrc;
  int n_errors = 0, samples_checked = 0, cycles = 0;

  always #5 clk_sys = ~clk_sys;

  tlic_top #(.NUM_SRC(6), .HAS_PRIO_DISABLE(1'b1)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .src_flag_i(flags),
    .call_req_o(creq), .call_vector_o(cvec), .call_source_o(csrc), .call_high_o(chigh),
    .call_ack_i(cack), .return_from_interrupt_i(return_from_interrupt), .plain_return_o(plain),
    .high_in_progress_o(hbusy), .low_in_progress_o(lbusy), .machine_state_o(), .irq_o(irq));

  tlic_core_model core_u (.clk_sys(clk_sys), .rst_n(rst_n), .call_req(creq),
    .ack_delay(dly), .call_ack(cack));

  task automatic report_and_stop;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Classic single cycle; ack and data are taken at the same edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    `CHK(ack, 1'b1, "no bus answer")
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    // Write lands on the ack edge; outputs settle one edge later
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    `CHK(q, {24'h0, e}, "read value")
  endtask : rd

  task automatic call_chk(input int src, input logic hi);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (creq !== 1'b1 && n < 40);
    `CHK(creq, 1'b1, "no call")
    `CHK(csrc, 3'(src), "call source")
    `CHK(cvec, tlic_pkg::VECTOR_BASE + tlic_pkg::VECTOR_STRIDE * 16'(src), "call vector")
    `CHK(chigh, hi, "call level")
    while (creq === 1'b1 && n < 80) begin
      @(posedge clk_sys);
      n++;
    end
    flags <= 6'h00;
  endtask : call_chk

  task automatic quiet;
    logic seen;
    seen = 1'b0;
    repeat (30) begin
      @(posedge clk_sys);
      seen = seen | creq;
    end
    `CHK(seen, 1'b0, "unexpected call")
  endtask : quiet

  task automatic ret(input logic exp_plain);
    @(posedge clk_sys);
    return_from_interrupt <= 1'b1;
    @(posedge clk_sys);
    return_from_interrupt <= 1'b0;
    @(posedge clk_sys);
    `CHK(plain, exp_plain, "plain return pulse")
  endtask : ret

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(tlic_pkg::ADDR_ENABLE, 8'h00);
    rd(tlic_pkg::ADDR_PRIORITY, 8'h00);
    wr(tlic_pkg::ADDR_ENABLE, 8'hFF);
    rd(tlic_pkg::ADDR_ENABLE, 8'hBF);
    wr(tlic_pkg::ADDR_PRIORITY, 8'hFF);
    rd(tlic_pkg::ADDR_PRIORITY, 8'hBF);
    rd(8'h18, 8'h00);
    wr(tlic_pkg::ADDR_PRIORITY, 8'h00);
    wr(tlic_pkg::ADDR_ENABLE, 8'h3F);
    flags <= 6'h3F;
    quiet();
    flags <= 6'h01;
    wr(tlic_pkg::ADDR_ENABLE, 8'hBE);
    quiet();
    // Flush the stale ext0 sample so no call slips in before the loop
    flags <= 6'h00;
    wr(tlic_pkg::ADDR_MASK, 8'h01);
    quiet();
    wr(tlic_pkg::ADDR_ENABLE, 8'hFF);
    // Higher sources held high too, so each pick shows the poll order
    for (int i = 0; i < 6; i++) begin
      dly <= 4'(i);
      flags <= 6'(6'h3F << i);
      call_chk(i, 1'b0);
      `CHK(irq, 1'b1, "irq after call")
      ret(1'b0);
      `CHK(lbusy, 1'b0, "low level left busy")
    end
    wr(tlic_pkg::ADDR_MASK, 8'h00);
    `CHK(irq, 1'b0, "masked irq")
    wr(tlic_pkg::ADDR_MASK, 8'h01);
    `CHK(irq, 1'b1, "unmasked irq")
    wr(tlic_pkg::ADDR_STATUS, 8'h07);
    `CHK(irq, 1'b0, "irq after clear")
    wr(tlic_pkg::ADDR_PRIORITY, 8'h20);
    flags <= 6'h21;
    call_chk(5, 1'b1);
    flags <= 6'h09;
    quiet();
    ret(1'b0);
    `CHK(hbusy, 1'b0, "high level left busy")
    call_chk(0, 1'b0);
    flags <= 6'h08;
    quiet();
    wr(tlic_pkg::ADDR_PRIORITY, 8'h88);
    quiet();
    wr(tlic_pkg::ADDR_PRIORITY, 8'h08);
    call_chk(3, 1'b1);
    ret(1'b0);
    `CHK({hbusy, lbusy}, 2'b01, "high cleared first")
    ret(1'b0);
    `CHK(lbusy, 1'b0, "low cleared")
    ret(1'b1);
    report_and_stop();
  end
endmodule : tb_top
